//--- wocw_bank.sv
// Write-once configuration word bank with table access port
`timescale 1ns/1ps

module wocw_bank
    import wocw_pkg::*;
(
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic                      i_por,
    input  wire logic                      i_tbl_rd,
    input  wire logic                      i_tbl_wr,
    input  wire logic [23:0]               i_tbl_addr,
    input  wire logic [15:0]               i_tbl_wdata,
    input  wire logic                      i_data_rd,
    input  wire logic                      i_data_wr,
    input  wire logic [23:0]               i_data_addr,
    output logic      [15:0]               o_tbl_rdata,
    output logic                           o_tbl_rvalid,
    output logic                           o_wr_ignored,
    output logic                           o_data_blocked,
    output logic      [WOCW_WORDS*8-1:0]   o_cfg_bits
);

    typedef struct packed {
        logic [WOCW_WORDS-1:0][7:0] cfg;
        logic [15:0]                rdata;
        logic                       rvalid;
        logic                       ign;
        logic                       blk;
    } wocw_state_s;

    wocw_state_s s_reg;
    wocw_state_s s_next;

    logic                       tbl_in_bank;
    logic [WOCW_IDX_W-1:0]      tbl_idx;
    logic                       tbl_hit;
    logic                       data_in_cfg;
    logic [WOCW_WORDS-1:0][7:0] wr_val;
    logic [WOCW_WORDS-1:0][7:0] rd_val;
    logic [WOCW_WORDS-1:0]      wr_rejected;

    // Word decode; bit 0 of the byte address is ignored
    // consecutive word map
    assign tbl_idx     = i_tbl_addr[4:1];
    assign tbl_in_bank = (i_tbl_addr[23:5] == WOCW_CFG_BASE[23:5]);
    assign tbl_hit     = tbl_in_bank &&
                         (tbl_idx < WOCW_IDX_W'(WOCW_WORDS));

    // data side never enters configuration space
    assign data_in_cfg = (i_data_rd || i_data_wr) &&
                         (i_data_addr >= WOCW_CFG_SPACE_LO);

    // Per-word write and read values
    genvar g;
    generate
        for (g = 0; g < WOCW_WORDS; g++) begin : g_word
            // a write can only clear, never restore a bit
            assign wr_val[g] = s_reg.cfg[g] &
                               (i_tbl_wdata[7:0] | ~WOCW_IMPL_MASK[g]);
            // Ones aimed at programmed bits are dropped and flagged
            assign wr_rejected[g] = |(~s_reg.cfg[g] & i_tbl_wdata[7:0] &
                                      WOCW_IMPL_MASK[g]);
            // reserved debug bits forced to one on read
            // oscillator reserved bit reads stored value
            assign rd_val[g] = s_reg.cfg[g] | WOCW_FORCE_ONE[g];
        end
    endgenerate

    // Next-state logic for the whole bank
    always_comb begin
        s_next        = s_reg;
        s_next.rvalid = 1'b0;
        s_next.ign    = 1'b0;
        s_next.blk    = data_in_cfg;
        if (i_tbl_rd) begin
            s_next.rvalid = 1'b1;
            // upper byte has no storage and reads ones
            if (tbl_hit) begin
                s_next.rdata = {WOCW_UPPER_BYTE, rd_val[tbl_idx]};
            end else begin
                s_next.rdata = WOCW_UNMAPPED_RD;
            end
        end
        // user ID bytes share the same write path
        if (i_tbl_wr && tbl_hit) begin
            s_next.cfg[tbl_idx] = wr_val[tbl_idx];
            s_next.ign          = wr_rejected[tbl_idx];
        end
    end

    // Registered state; reset spares the configuration bits
    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (i_rst) begin
                s_reg.rdata  <= WOCW_RDATA_RST;
                s_reg.rvalid <= 1'b0;
                s_reg.ign    <= 1'b0;
                s_reg.blk    <= 1'b0;
            end else begin
                s_reg <= s_next;
            end
            if (i_por) begin
                s_reg.cfg <= {WOCW_WORDS{WOCW_ERASED_BYTE}};
            end
        end
    end

    // Outputs straight from flip-flops
    assign o_tbl_rdata    = s_reg.rdata;
    assign o_tbl_rvalid   = s_reg.rvalid;
    assign o_wr_ignored   = s_reg.ign;
    assign o_data_blocked = s_reg.blk;
    assign o_cfg_bits     = s_reg.cfg;

    // Checks, mostly gated by act; ce_freeze_a samples while the clock enable is low
    logic act;
    // Requests only count while running, out of reset and power-on
    assign act = i_ce && !i_rst && !i_por;

    sequence rd_word_s(logic [3:0] k);
        act && i_tbl_rd && tbl_hit && tbl_idx == k;
    endsequence

    sequence wr_word_s;
        act && i_tbl_wr && tbl_hit;
    endsequence

    sequence quiet_s;
        act && !i_tbl_wr;
    endsequence

    // read shows stored pattern of any word
    read_back_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_rd && tbl_hit && i_ce |=> o_tbl_rvalid &&
        o_tbl_rdata[7:0] == $past(rd_val[tbl_idx])
    ) else $error("read data does not match stored word");

    // base location maps to the first word
    base_map_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_rd && i_tbl_addr == OFS_BOOT_SEGMENT_PROTECT |=>
        o_tbl_rdata[7:0] == $past(s_reg.cfg[0])
    ) else $error("base location not mapped to first word");

    // data write into config space is refused
    data_block_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_data_wr && i_data_addr >= WOCW_CFG_SPACE_LO &&
        !i_tbl_wr |=> o_data_blocked && $stable(s_reg.cfg)
    ) else $error("data access reached configuration space");

    upper_ones_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_rd |=> o_tbl_rdata[15:8] == WOCW_UPPER_BYTE
    ) else $error("upper byte of read data not all ones");

    // no bit returns to one without power-on
    once_lock_a: assert property (
        @(posedge i_core_clk)
        !i_por |=> (s_reg.cfg & ~$past(s_reg.cfg)) == '0
    ) else $error("programmed bit was restored without power-on");

    // rejected ones raise the ignore flag
    ignore_flag_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        wr_word_s ##0 (wr_rejected[tbl_idx]) |=> o_wr_ignored ##1
        (o_wr_ignored == $past(act && i_tbl_wr && tbl_hit &&
                               wr_rejected[tbl_idx]))
    ) else $error("ignore flag does not follow rejected write");

    // debug reserved bits read as ones
    dbg_reserved_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        rd_word_s(IDX_DEBUG_PORT) |=>
        (o_tbl_rdata[7:0] & DBG_RSVD_BITS) == DBG_RSVD_BITS
    ) else $error("debug reserved bits not read as one");

    // oscillator reserved bit tracks stored value
    osc_reserved_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        rd_word_s(IDX_OSC_SOURCE) |=>
        (o_tbl_rdata[7:0] & OSC_RSVD_BIT) ==
        ($past(s_reg.cfg[IDX_OSC_SOURCE]) & OSC_RSVD_BIT)
    ) else $error("oscillator reserved bit not stored value");

    // user ID byte programs freely once
    uid_write_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        wr_word_s ##0 (tbl_idx == IDX_UID_BYTE0) |=>
        s_reg.cfg[IDX_UID_BYTE0] ==
        ($past(s_reg.cfg[IDX_UID_BYTE0]) & $past(i_tbl_wdata[7:0]))
    ) else $error("user ID byte write not applied");

    por_clear_a: assert property (
        @(posedge i_core_clk)
        i_ce && i_por |=> s_reg.cfg == {WOCW_WORDS{WOCW_ERASED_BYTE}}
    ) else $error("power-on did not erase the bank");

    // reset held two cycles leaves bank intact
    rst_keep_a: assert property (
        @(posedge i_core_clk)
        (i_rst && !i_por) [*2] |=> s_reg.cfg == $past(s_reg.cfg, 2)
    ) else $error("plain reset altered configuration bits");

    // Frozen clock enable holds read data, valid and config bits
    ce_freeze_a: assert property (
        @(posedge i_core_clk)
        !i_ce |=> $stable(o_tbl_rdata) && $stable(o_cfg_bits) &&
        $stable(o_tbl_rvalid)
    ) else $error("state moved while clock enable low");

    // Two cycles without a table write leave the bank alone
    quiet_hold_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        quiet_s ##1 quiet_s |=> $stable(s_reg.cfg)
    ) else $error("bank changed without a table write");

    // Writes past the last word must not alias into the bank
    unmapped_wr_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_wr && !tbl_hit |=> $stable(s_reg.cfg)
    ) else $error("unmapped write changed the bank");

    // Unmapped reads return all ones
    unmapped_rd_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_rd && !tbl_hit |=> o_tbl_rdata == WOCW_UNMAPPED_RD
    ) else $error("unmapped read not all ones");

    // Data reads into configuration space are refused too
    data_rd_block_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_data_rd && i_data_addr >= WOCW_CFG_SPACE_LO |=>
        o_data_blocked
    ) else $error("data read reached configuration space");

    // Data accesses below the space are not flagged
    data_low_pass_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && !(data_in_cfg) |=> !o_data_blocked
    ) else $error("data access flagged outside configuration space");

    // Unimplemented bits hold their erased ones forever
    impl_ones_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act |=> (s_reg.cfg | WOCW_IMPL_MASK) ==
        {WOCW_WORDS{WOCW_ERASED_BYTE}}
    ) else $error("unimplemented configuration bit cleared");

    // Ignore flag only follows a mapped write
    ign_needs_wr_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && !(i_tbl_wr && tbl_hit) |=> !o_wr_ignored
    ) else $error("ignore flag without a write");

    // Reserved debug bits stay stored as ones after a write
    dbg_store_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        wr_word_s ##0 (tbl_idx == IDX_DEBUG_PORT) |=>
        (s_reg.cfg[IDX_DEBUG_PORT] & ~WOCW_IMPL_MASK[IDX_DEBUG_PORT]) ==
        ~WOCW_IMPL_MASK[IDX_DEBUG_PORT]
    ) else $error("debug reserved bits stored as zero");

    // Every accepted read gives a valid pulse
    rd_valid_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && i_tbl_rd |=> o_tbl_rvalid
    ) else $error("read without valid pulse");

    // Valid pulse lasts only one cycle
    rvalid_pulse_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && !i_tbl_rd |=> !o_tbl_rvalid
    ) else $error("valid pulse without a read");

    // Read data stands until the next read
    rdata_hold_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        act && !i_tbl_rd |=> $stable(o_tbl_rdata)
    ) else $error("read data changed without a read");

    // Plain reset clears the read side and both flags
    rst_clear_a: assert property (
        @(posedge i_core_clk)
        i_ce && i_rst |=> o_tbl_rdata == WOCW_RDATA_RST &&
        !o_tbl_rvalid && !o_wr_ignored && !o_data_blocked
    ) else $error("reset did not clear outputs");

endmodule : wocw_bank

//--- wocw_pkg.sv
// Constants for the write-once configuration word bank
// Notes on behaviour
// - Programmed bit reads 0, unprogrammed reads 1.
// - Words sit consecutively from base 0xF80000.
// - Only table accesses reach configuration space.
// - Writing upper byte ones changes nothing.
// - Each bit programs once per power cycle.
// - Debug word reserved bits read as one.
// - Oscillator reserved bit returns programmed value.
package wocw_pkg;

    // Configuration space and bank placement
    localparam logic [23:0] WOCW_CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] WOCW_CFG_BASE     = 24'hf80000;
    localparam int          WOCW_WORDS        = 12;
    localparam int          WOCW_IDX_W        = 4;

    // Byte offsets of each word
    localparam logic [23:0] OFS_BOOT_SEGMENT_PROTECT    = 24'hf80000;
    localparam logic [23:0] OFS_SECURE_SEGMENT_PROTECT  = 24'hf80002;
    localparam logic [23:0] OFS_GENERAL_SEGMENT_PROTECT = 24'hf80004;
    localparam logic [23:0] OFS_OSCILLATOR_SOURCE_SELECT = 24'hf80006;
    localparam logic [23:0] OFS_OSCILLATOR_SETUP        = 24'hf80008;
    localparam logic [23:0] OFS_WATCHDOG_SETUP          = 24'hf8000a;
    localparam logic [23:0] OFS_POWER_ON_RESET_SETUP    = 24'hf8000c;
    localparam logic [23:0] OFS_DEBUG_PORT_SETUP        = 24'hf8000e;
    localparam logic [23:0] OFS_USER_UNIT_ID_BYTE0      = 24'hf80010;
    localparam logic [23:0] OFS_USER_UNIT_ID_BYTE1      = 24'hf80012;
    localparam logic [23:0] OFS_USER_UNIT_ID_BYTE2      = 24'hf80014;
    localparam logic [23:0] OFS_USER_UNIT_ID_BYTE3      = 24'hf80016;

    // Word indexes used by the checks
    localparam logic [3:0] IDX_OSC_SOURCE = 4'h3;
    localparam logic [3:0] IDX_DEBUG_PORT = 4'h7;
    localparam logic [3:0] IDX_UID_BYTE0  = 4'h8;

    // Implemented bits per word, index 11 first
    localparam logic [WOCW_WORDS-1:0][7:0] WOCW_IMPL_MASK = {
        8'hff, 8'hff, 8'hff, 8'hff,
        8'h23, 8'h07, 8'hdf, 8'hc7,
        8'hc7, 8'h07, 8'hcf, 8'hcf
    };
    // Bits that always read as one, index 11 first
    localparam logic [WOCW_WORDS-1:0][7:0] WOCW_FORCE_ONE = {
        8'h00, 8'h00, 8'h00, 8'h00,
        8'hc0, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00
    };
    localparam logic [7:0]  DBG_RSVD_BITS = 8'hc0;
    localparam logic [7:0]  OSC_RSVD_BIT  = 8'h40;

    // Read and reset values
    localparam logic [7:0]  WOCW_UPPER_BYTE  = 8'hff;
    localparam logic [7:0]  WOCW_ERASED_BYTE = 8'hff;
    localparam logic [15:0] WOCW_UNMAPPED_RD = 16'hffff;
    localparam logic [15:0] WOCW_RDATA_RST   = 16'h0000;
    localparam int          WOCW_RD_LATENCY  = 1;

endpackage : wocw_pkg

//--- tb_write_once_config_words.sv
// Self-checking bench for the write-once configuration word bank
`timescale 1ns/1ps

module tb_write_once_config_words;
    import wocw_pkg::*;

    logic                    i_core_clk = 1'b0;
    logic                    i_rst = 1'b1;
    logic                    i_por = 1'b1;
    logic                    i_ce = 1'b1;
    logic                    i_tbl_rd = 1'b0;
    logic                    i_tbl_wr = 1'b0;
    logic                    i_data_rd = 1'b0;
    logic                    i_data_wr = 1'b0;
    logic [23:0]             i_tbl_addr = 24'h000000;
    logic [15:0]             i_tbl_wdata = 16'h0000;
    logic [23:0]             i_data_addr = 24'h000000;
    logic [15:0]             o_tbl_rdata;
    logic                    o_tbl_rvalid;
    logic                    o_wr_ignored;
    logic                    o_data_blocked;
    logic [WOCW_WORDS*8-1:0] o_cfg_bits;
    logic [15:0]             rd_v;
    logic [7:0]              exp_b;
    int                      error_cnt = 0;
    int                      checks_done = 0;

    // Clock enable driven so freezing can be exercised
    wocw_bank dut_u (.i_core_clk, .i_rst, .i_ce, .i_por, .i_tbl_rd,
        .i_tbl_wr, .i_tbl_addr, .i_tbl_wdata, .i_data_rd, .i_data_wr,
        .i_data_addr, .o_tbl_rdata, .o_tbl_rvalid, .o_wr_ignored,
        .o_data_blocked, .o_cfg_bits);

    // Free-running 125 MHz clock
    initial begin
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic chk_word(input string n, input logic [15:0] e,
                            input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic chk_flag(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask : chk_flag

    // Sample one step after the edge so registered outputs have landed
    task automatic tbl_read(input logic [23:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        i_tbl_rd   <= 1'b1;
        i_tbl_addr <= a;
        @(posedge i_core_clk);
        i_tbl_rd <= 1'b0;
        #1;
        chk_flag("read valid", 1'b1, o_tbl_rvalid);
        d = o_tbl_rdata;
    endtask : tbl_read

    task automatic tbl_write(input logic [23:0] a, input logic [15:0] w,
                             input logic ign);
        @(posedge i_core_clk);
        i_tbl_wr    <= 1'b1;
        i_tbl_addr  <= a;
        i_tbl_wdata <= w;
        @(posedge i_core_clk);
        i_tbl_wr <= 1'b0;
        #1;
        chk_flag("write ignored", ign, o_wr_ignored);
    endtask : tbl_write

    task automatic data_acc(input logic [23:0] a, input logic wr,
                            input logic blk);
        @(posedge i_core_clk);
        i_data_rd   <= !wr;
        i_data_wr   <= wr;
        i_data_addr <= a;
        @(posedge i_core_clk);
        i_data_rd <= 1'b0;
        i_data_wr <= 1'b0;
        #1;
        chk_flag("data blocked", blk, o_data_blocked);
    endtask : data_acc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Hang guard, far beyond the roughly 130 cycles the tests need
    initial begin
        repeat (5000) @(posedge i_core_clk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence; power-on erase rides along with the first reset
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        i_por <= 1'b0;
        for (int k = 0; k < WOCW_WORDS; k++) begin
            tbl_read(WOCW_CFG_BASE + 24'(2 * k), rd_v);
            chk_word("erased word", 16'hffff, rd_v);
        end
        $display("test erased bank done");
        // Upper byte kept all ones, then a second write tries to undo
        for (int k = 0; k < WOCW_WORDS; k++) begin
            tbl_write(WOCW_CFG_BASE + 24'(2 * k),
                      16'hff3a | ((k == 7) ? 16'h00c0 : 16'h0000),
                      1'b0);
            tbl_write(WOCW_CFG_BASE + 24'(2 * k), 16'hffff, 1'b1);
            exp_b = 8'h3a | ~WOCW_IMPL_MASK[k] | WOCW_FORCE_ONE[k];
            tbl_read(WOCW_CFG_BASE + 24'(2 * k), rd_v);
            chk_word("programmed word", {8'hff, exp_b}, rd_v);
            exp_b = 8'h3a | ~WOCW_IMPL_MASK[k];
            chk_word("bank byte", {8'h00, exp_b},
                     {8'h00, o_cfg_bits[8*k +: 8]});
        end
        tbl_write(24'hf80018, 16'h0000, 1'b0);
        tbl_read(24'hf80018, rd_v);
        chk_word("unmapped word", 16'hffff, rd_v);
        $display("test write once done");
        // Ordinary reset must leave the locks in place
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk_word("read data after reset", 16'h0000, o_tbl_rdata);
        tbl_write(WOCW_CFG_BASE, 16'hffff, 1'b1);
        tbl_read(WOCW_CFG_BASE, rd_v);
        chk_word("word after reset", {8'hff, 8'h3a | 8'h30}, rd_v);
        $display("test reset keeps locks done");
        // Data accesses into configuration space are turned away
        data_acc(24'hf80000, 1'b1, 1'b1);
        data_acc(24'h800000, 1'b0, 1'b1);
        data_acc(24'h7ffffe, 1'b1, 1'b0);
        tbl_read(WOCW_CFG_BASE, rd_v);
        chk_word("word after data", 16'hff3a | 16'h0030, rd_v);
        $display("test data refusal done");
        // Power cycle erases and allows programming again
        @(posedge i_core_clk);
        i_por <= 1'b1;
        @(posedge i_core_clk);
        i_por <= 1'b0;
        tbl_read(OFS_USER_UNIT_ID_BYTE3, rd_v);
        chk_word("word after power", 16'hffff, rd_v);
        tbl_write(OFS_USER_UNIT_ID_BYTE3, 16'hff00, 1'b0);
        tbl_read(OFS_USER_UNIT_ID_BYTE3, rd_v);
        chk_word("id byte reprogram", 16'hff00, rd_v);
        // Clock enable low: a write must not land
        @(posedge i_core_clk);
        i_ce <= 1'b0;
        tbl_write(OFS_USER_UNIT_ID_BYTE2, 16'hff55, 1'b0);
        chk_word("frozen id byte", 16'h00ff, {8'h00, o_cfg_bits[80 +: 8]});
        @(posedge i_core_clk);
        i_ce <= 1'b1;
        tbl_read(OFS_USER_UNIT_ID_BYTE2, rd_v);
        chk_word("id byte after freeze", 16'hffff, rd_v);
        $display("test power cycle done");
        print_verdict();
    end

endmodule : tb_write_once_config_words
